/* File: pkg/apm_pkg.sv */
package apm_pkg;
  // byte and buffer geometry
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [2:0] HDR_LEN = 3'h5; // class, ins, p1, p2, p3
  localparam logic [8:0] FULL_LEN = 9'h100; // le of zero means this many
  localparam logic [8:0] IFSD = 9'h020; // bytes per outgoing block, plain default

  // procedure bytes and status words
  localparam logic [7:0] PB_GET = 8'h61; // ask terminal to fetch remainder
  localparam logic [7:0] PB_RESEND = 8'h6C; // ask terminal to resend header
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_FALLBACK = 16'h6F00; // substituted for ok on error in t0
  localparam logic [7:0] SW1_WARN_A = 8'h62;
  localparam logic [7:0] SW1_WARN_B = 8'h63;
  localparam logic [3:0] SW1_APP_NIB = 4'h9;

  // command case as decided by the card application
  typedef enum logic [1:0] {CASE1, CASE2, CASE3, CASE4} apm_case_t;

  // transport sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_HDR, S_APP, S_ACK, S_DATA_IN, S_EXEC,
    S_DATA_OUT, S_SEND_SW1, S_SEND_SW2, S_T1_CMD, S_T1_EXEC
  } apm_state_t;

  // five byte command header, class first
  typedef struct packed {
    logic [7:0] cla;
    logic [7:0] ins;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
  } apm_hdr_t;

  // one byte on the link with block framing marks (block protocol only)
  typedef struct packed {
    logic [7:0] data;
    logic blk_end; // last byte of a block information field
    logic chained; // block is chained to the next one
  } apm_link_t;

  // decision or completion from the card application
  typedef struct packed {
    apm_case_t cse;
    logic abnormal;
    logic [15:0] sw;
    logic [8:0] avail; // response bytes available, 0 to 256
  } apm_app_t;
endpackage

/* File: design/apm_fifo.sv */
`timescale 1ns/1ps
// response byte buffer; flags are registered so ready and valid leave flops
module apm_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  logic [W-1:0] mem [D]; // storage flops
  logic [AW-1:0] wr_ptr, next_wr_ptr;
  logic [AW-1:0] rd_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic next_in_ready; // room for one more word
  logic next_out_valid; // at least one word held
  logic push, pop;

  assign out_data = mem[rd_ptr];

  // pointer and level update
  always_comb begin
    push = in_valid && in_ready;
    pop = out_ready && out_valid;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
    next_in_ready = (next_count != CW'(D));
    next_out_valid = (next_count != '0);
  end

  // state registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= next_in_ready;
      out_valid <= next_out_valid;
    end
  end

  // storage has no reset; only written slots are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

/* File: design/apm_transport.sv */
`timescale 1ns/1ps
// Rules for the card and the terminal
// RL1: case 2 gives data and status, or status
// RL2: terminal keeps case 3 length 1 to 255
// RL3: terminal sends data after procedure byte only
// RL4: case 3 status only after data and execution
// RL5: terminal drops trailing le byte in case 4
// RL6: case 4 normal gives 61xx, abnormal gives status
// RL7: terminal fetches at most xx after 61xx
// RL8: terminal fetches with le zero after warnings
// RL9: terminal abandons case 4 on other status
// RL10: fetch command is handled as case 2
// RL11: procedure bytes only for t0 cases 2, 4
// RL12: terminal resends header with p3 from 6Cxx
// RL13: error status may replace procedure bytes
// RL14: case 2 oversized or zero le gives 6C
// RL15: case 2 exact le sends data then status
// RL16: case 2 smaller le: data, then 61 remainder
// RL17: case 4 end gives 61xx or non-ok status
// RL18: data fills body, status goes unchanged in trailer
// RL19: block protocol carries command and response unaltered
// RL20: block protocol data only with allowed status classes
// RL21: long block responses are chained
// RL22: chained command blocks are joined
// RL23: terminal sends p3 zero for case 1
// RL24: terminal keeps procedure bytes internal
// RL25: header is five bytes, class through p3
module apm_transport (
  input wire logic clk,
  input wire logic rstn,
  input wire logic t1_mode, // block protocol when high, sampled between commands
  input wire logic rx_valid,
  input wire apm_pkg::apm_link_t rx,
  output logic rx_ready,
  output logic tx_valid,
  output apm_pkg::apm_link_t tx,
  input wire logic tx_ready,
  output logic hdr_valid,
  output apm_pkg::apm_hdr_t hdr,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic cmd_end,
  input wire logic cmd_ready,
  output logic app_wait,
  input wire logic app_valid,
  input wire apm_pkg::apm_app_t app,
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  output logic resp_ready
);
  apm_pkg::apm_state_t state, next_state; // sequencer
  apm_pkg::apm_hdr_t next_hdr;
  apm_pkg::apm_case_t cse, next_cse; // case of the current command
  apm_pkg::apm_link_t next_tx;
  logic [2:0] hcnt, next_hcnt; // header bytes taken
  logic [8:0] cnt, next_cnt; // data bytes left to move
  logic [8:0] blk, next_blk; // bytes in current outgoing block
  logic [15:0] pair, next_pair; // two bytes to send next
  logic [15:0] after, next_after; // pair that follows outgoing data
  logic pair_proc, next_pair_proc; // pair is a procedure byte pair
  logic after_proc, next_after_proc;
  logic out_dir, next_out_dir; // after ack: send data, else receive
  logic t1, next_t1; // protocol of the current command
  logic next_tx_valid, next_rx_ready, next_hdr_valid;
  logic next_cmd_valid, next_cmd_end, next_app_wait;
  logic [7:0] next_cmd_byte;
  logic send_ok, rx_take, pop, load, load_final, blk_last;
  logic [7:0] load_data;
  logic [8:0] eff_le; // expected length, zero read as 256
  logic [8:0] rem; // bytes left after a partial return
  logic fifo_valid;
  logic [7:0] fifo_data;

  // ok status is never allowed to report a failure in t0
  function automatic logic [15:0] fix_sw(input logic [15:0] sw);
    return (sw == apm_pkg::SW_OK) ? apm_pkg::SW_FALLBACK : sw;
  endfunction

  // warning, application or ok classes may carry data
  function automatic logic data_allowed(input logic [15:0] sw);
    return (sw[15:8] == apm_pkg::SW1_WARN_A) || (sw[15:8] == apm_pkg::SW1_WARN_B) ||
      (sw[15:12] == apm_pkg::SW1_APP_NIB);
  endfunction

  // response bytes from the application wait here until the link drains them
  apm_fifo #(.W(apm_pkg::BYTE_W), .D(apm_pkg::FIFO_DEPTH)) u_resp_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(resp_valid),
    .in_data(resp_data),
    .in_ready(resp_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(pop)
  );

  // next-state logic for the whole sequencer
  always_comb begin
    next_state = state;
    next_hdr = hdr;
    next_cse = cse;
    next_hcnt = hcnt;
    next_cnt = cnt;
    next_blk = blk;
    next_pair = pair;
    next_after = after;
    next_pair_proc = pair_proc;
    next_after_proc = after_proc;
    next_out_dir = out_dir;
    next_t1 = t1;
    next_tx = tx;
    next_tx_valid = tx_valid;
    next_hdr_valid = 1'b0;
    next_cmd_valid = cmd_valid;
    next_cmd_byte = cmd_byte;
    next_cmd_end = cmd_end;
    pop = 1'b0;
    load = 1'b0;
    load_final = 1'b0;
    load_data = 8'h00;
    blk_last = 1'b0;
    send_ok = !tx_valid || tx_ready; // output slot free this cycle
    rx_take = rx_valid && rx_ready;
    eff_le = (hdr.p3 == 8'h00) ? apm_pkg::FULL_LEN : {1'b0, hdr.p3};
    rem = app.avail - eff_le;
    if (tx_valid && tx_ready) begin
      next_tx_valid = 1'b0;
    end
    if (cmd_valid && cmd_ready) begin
      next_cmd_valid = 1'b0;
    end
    unique case (state)
      // pick the protocol once per command
      apm_pkg::S_IDLE: begin
        next_t1 = t1_mode;
        next_hcnt = 3'h0;
        next_blk = 9'h000;
        next_state = t1_mode ? apm_pkg::S_T1_CMD : apm_pkg::S_HDR;
      end
      // header shifts in class first
      apm_pkg::S_HDR: begin
        if (rx_take) begin
          next_hdr = apm_pkg::apm_hdr_t'({hdr[31:0], rx.data}); // RL25
          next_hcnt = hcnt + 3'h1;
          if (hcnt == apm_pkg::HDR_LEN - 3'h1) begin
            next_hdr_valid = 1'b1;
            next_state = apm_pkg::S_APP;
          end
        end
      end
      // application has looked at the header
      apm_pkg::S_APP: begin
        if (app_valid) begin
          next_cse = app.cse;
          next_pair_proc = 1'b0;
          next_state = apm_pkg::S_SEND_SW1;
          if (app.abnormal) begin
            next_pair = fix_sw(app.sw); // RL1 RL13
          end else if (app.cse == apm_pkg::CASE1) begin
            next_pair = app.sw;
          end else if (app.cse != apm_pkg::CASE2) begin
            next_cnt = eff_le; // zero length read as 256
            next_out_dir = 1'b0;
            next_state = apm_pkg::S_ACK;
          end else if (eff_le > app.avail ||
              (hdr.p3 == 8'h00 && app.avail != apm_pkg::FULL_LEN)) begin
            next_pair = {apm_pkg::PB_RESEND, app.avail[7:0]}; // RL14 RL11
            next_pair_proc = 1'b1;
          end else if (eff_le == app.avail) begin
            next_cnt = app.avail; // RL15
            next_after = app.sw; // RL18
            next_after_proc = 1'b0;
            next_out_dir = 1'b1;
            next_state = apm_pkg::S_ACK;
          end else begin
            next_cnt = eff_le; // RL16
            next_after = {apm_pkg::PB_GET, rem[7:0]};
            next_after_proc = 1'b1;
            next_out_dir = 1'b1;
            next_state = apm_pkg::S_ACK;
          end
        end
      end
      // ins procedure byte opens the data phase
      apm_pkg::S_ACK: begin
        if (send_ok) begin
          load = 1'b1;
          load_data = hdr.ins;
          next_state = out_dir ? apm_pkg::S_DATA_OUT : apm_pkg::S_DATA_IN;
        end
      end
      // command data passed on to the application
      apm_pkg::S_DATA_IN: begin
        if (rx_take) begin
          next_cmd_valid = 1'b1;
          next_cmd_byte = rx.data;
          next_cmd_end = (cnt == 9'h001);
          next_cnt = cnt - 9'h001;
          if (cnt == 9'h001) begin
            next_state = apm_pkg::S_EXEC; // RL4
          end
        end
      end
      // execution result after all command data
      apm_pkg::S_EXEC: begin
        if (app_valid) begin
          next_state = apm_pkg::S_SEND_SW1;
          next_pair_proc = 1'b0;
          if (cse == apm_pkg::CASE3) begin
            next_pair = app.abnormal ? fix_sw(app.sw) : app.sw; // RL4
          end else if (app.abnormal) begin
            next_pair = fix_sw(app.sw); // RL6 RL17
          end else begin
            next_pair = {apm_pkg::PB_GET, app.avail[7:0]}; // RL6 RL17 RL10
            next_pair_proc = 1'b1;
          end
        end
      end
      // response body straight from the buffer
      apm_pkg::S_DATA_OUT: begin
        if (send_ok && fifo_valid) begin
          pop = 1'b1;
          load = 1'b1;
          load_data = fifo_data; // RL18 RL19
          next_cnt = cnt - 9'h001;
          if (cnt == 9'h001) begin
            next_pair = after;
            next_pair_proc = after_proc;
            next_state = apm_pkg::S_SEND_SW1;
          end
        end
      end
      apm_pkg::S_SEND_SW1: begin
        if (send_ok) begin
          load = 1'b1;
          load_data = pair[15:8];
          next_state = apm_pkg::S_SEND_SW2;
        end
      end
      // last byte closes the exchange
      apm_pkg::S_SEND_SW2: begin
        if (send_ok) begin
          load = 1'b1;
          load_final = 1'b1;
          load_data = pair[7:0];
          next_state = apm_pkg::S_IDLE;
        end
      end
      // block protocol: the whole command passes through unaltered
      apm_pkg::S_T1_CMD: begin
        if (rx_take) begin
          next_cmd_valid = 1'b1;
          next_cmd_byte = rx.data; // RL19
          next_cmd_end = rx.blk_end && !rx.chained; // RL22
          if (rx.blk_end && !rx.chained) begin
            next_state = apm_pkg::S_T1_EXEC;
          end
        end
      end
      apm_pkg::S_T1_EXEC: begin
        if (app_valid) begin
          next_pair_proc = 1'b0;
          next_after_proc = 1'b0;
          next_pair = app.sw;
          next_after = app.sw;
          if (data_allowed(app.sw) && app.avail != 9'h000) begin
            next_cnt = app.avail; // RL20
            next_state = apm_pkg::S_DATA_OUT;
          end else begin
            next_state = apm_pkg::S_SEND_SW1;
          end
        end
      end
      default: begin
        next_state = apm_pkg::S_IDLE;
      end
    endcase
    // framing of every byte loaded onto the link
    if (load) begin
      blk_last = t1 && (load_final || blk == apm_pkg::IFSD - 9'h001);
      next_tx_valid = 1'b1;
      next_tx.data = load_data;
      next_tx.blk_end = blk_last;
      next_tx.chained = blk_last && !load_final; // RL21
      next_blk = blk_last ? 9'h000 : blk + 9'h001;
    end
    // registered ready goes low on the same edge that a byte fills the slot
    next_rx_ready = (next_state == apm_pkg::S_HDR) ||
      ((next_state == apm_pkg::S_DATA_IN || next_state == apm_pkg::S_T1_CMD) &&
      !next_cmd_valid);
    next_app_wait = (next_state == apm_pkg::S_APP) || (next_state == apm_pkg::S_EXEC) ||
      (next_state == apm_pkg::S_T1_EXEC);
  end

  // sequencer registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= apm_pkg::S_IDLE;
      hdr <= '0;
      cse <= apm_pkg::CASE1;
      hcnt <= 3'h0;
      cnt <= 9'h000;
      blk <= 9'h000;
      pair <= 16'h0000;
      after <= 16'h0000;
      pair_proc <= 1'b0;
      after_proc <= 1'b0;
      out_dir <= 1'b0;
      t1 <= 1'b0;
      tx <= '0;
      tx_valid <= 1'b0;
      rx_ready <= 1'b0;
      hdr_valid <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_byte <= 8'h00;
      cmd_end <= 1'b0;
      app_wait <= 1'b0;
    end else begin
      state <= next_state;
      hdr <= next_hdr;
      cse <= next_cse;
      hcnt <= next_hcnt;
      cnt <= next_cnt;
      blk <= next_blk;
      pair <= next_pair;
      after <= next_after;
      pair_proc <= next_pair_proc;
      after_proc <= next_after_proc;
      out_dir <= next_out_dir;
      t1 <= next_t1;
      tx <= next_tx;
      tx_valid <= next_tx_valid;
      rx_ready <= next_rx_ready;
      hdr_valid <= next_hdr_valid;
      cmd_valid <= next_cmd_valid;
      cmd_byte <= next_cmd_byte;
      cmd_end <= next_cmd_end;
      app_wait <= next_app_wait;
    end
  end

  // checks on the sequencer
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_hdr_five;
    $rose(hdr_valid) |-> $past(hcnt) == 3'h4 && state == apm_pkg::S_APP;
  endproperty
  a_hdr_five: assert property (p_hdr_five) else $error("header not five bytes"); // RL25

  property p_abn_status;
    state == apm_pkg::S_APP && app_valid && app.abnormal |=>
      state == apm_pkg::S_SEND_SW1 && !pair_proc && pair != apm_pkg::SW_OK;
  endproperty
  a_abn_status: assert property (p_abn_status) else $error("abnormal not status only"); // RL1

  property p_resend;
    state == apm_pkg::S_APP && app_valid && !app.abnormal && app.cse == apm_pkg::CASE2 &&
      hdr.p3 == 8'h00 && app.avail != apm_pkg::FULL_LEN |=>
      pair == {apm_pkg::PB_RESEND, $past(app.avail[7:0])} ##[1:40] tx_valid &&
      tx.data == apm_pkg::PB_RESEND;
  endproperty
  a_resend: assert property (p_resend) else $error("6C not returned"); // RL14

  property p_exact;
    state == apm_pkg::S_APP && app_valid && !app.abnormal && app.cse == apm_pkg::CASE2 &&
      hdr.p3 != 8'h00 && {1'b0, hdr.p3} == app.avail |=>
      state == apm_pkg::S_ACK && cnt == $past(app.avail) && after == $past(app.sw);
  endproperty
  a_exact: assert property (p_exact) else $error("exact length not served"); // RL15

  property p_partial;
    state == apm_pkg::S_APP && app_valid && !app.abnormal && app.cse == apm_pkg::CASE2 &&
      hdr.p3 != 8'h00 && {1'b0, hdr.p3} < app.avail |=>
      after[15:8] == apm_pkg::PB_GET && cnt == {1'b0, hdr.p3};
  endproperty
  a_partial: assert property (p_partial) else $error("partial return wrong"); // RL16

  property p_case4_end;
    state == apm_pkg::S_EXEC && app_valid && cse == apm_pkg::CASE4 && !app.abnormal |=>
      pair == {apm_pkg::PB_GET, $past(app.avail[7:0])};
  endproperty
  a_case4_end: assert property (p_case4_end) else $error("case 4 missing 61xx"); // RL6 RL17

  property p_proc_scope;
    state == apm_pkg::S_SEND_SW1 && pair_proc |->
      !t1 && (cse == apm_pkg::CASE2 || cse == apm_pkg::CASE4);
  endproperty
  a_proc_scope: assert property (p_proc_scope) else $error("procedure bytes misused"); // RL11

  property p_exec_after_data;
    state == apm_pkg::S_EXEC |-> cnt == 9'h000 && !out_dir;
  endproperty
  a_exec_after_data: assert property (p_exec_after_data) else $error("status before data"); // RL4

  property p_t1_data_class;
    state == apm_pkg::S_DATA_OUT && t1 |-> data_allowed(after);
  endproperty
  a_t1_data_class: assert property (p_t1_data_class) else $error("data with bad status"); // RL20

  property p_chain;
    tx_valid && tx.chained |-> tx.blk_end && t1;
  endproperty
  a_chain: assert property (p_chain) else $error("chain mark off block end"); // RL21
endmodule

/* File: test/apm_term.sv */
`timescale 1ns/1ps
// terminal side of the link: offers queued bytes in order, takes card bytes
module apm_term (
  input wire logic clk,
  input wire logic rstn,
  input wire logic slow, // random stalls on the card's transmitter
  output logic rx_valid,
  output apm_pkg::apm_link_t rx,
  input wire logic rx_ready,
  input wire logic tx_valid,
  output logic tx_ready
);
  apm_pkg::apm_link_t q[$]; // bytes still to go, filled by the bench

  // offer held until taken; an idle line keeps moving so stale data never passes
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_valid <= 1'b0;
      rx <= '0;
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= slow ? 1'($urandom_range(1, 0)) : 1'b1;
      if (rx_valid && rx_ready) begin
        void'(q.pop_front());
      end
      if (q.size() > 0) begin
        rx_valid <= 1'b1;
        rx <= q[0];
      end else begin
        rx_valid <= 1'b0;
        rx.data <= ~rx.data;
      end
    end
  end
endmodule

/* File: test/test_apm_transport.sv */
`timescale 1ns/1ps
// walks the card transport through both protocols, byte by byte
module test_apm_transport;
  logic clk, rstn, t1_mode, slow, rx_valid, rx_ready, tx_valid, tx_ready;
  logic hdr_valid, cmd_valid, cmd_end, app_wait, app_valid, resp_valid, resp_ready;
  logic cmd_ready = 1'b0;
  apm_pkg::apm_link_t rx, tx;
  apm_pkg::apm_hdr_t hdr;
  apm_pkg::apm_app_t app;
  logic [7:0] cmd_byte, resp_data;
  int failures, n_checks, cyc, ecnt, etot, refused;
  apm_pkg::apm_link_t txq[$]; // card bytes still expected
  logic [8:0] cmdq[$]; // command bytes with end mark
  apm_pkg::apm_hdr_t hdrq[$]; // headers still expected

  apm_transport uut (.clk(clk), .rstn(rstn), .t1_mode(t1_mode), .rx_valid(rx_valid),
    .rx(rx), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx(tx), .tx_ready(tx_ready),
    .hdr_valid(hdr_valid), .hdr(hdr), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .cmd_end(cmd_end), .cmd_ready(cmd_ready), .app_wait(app_wait),
    .app_valid(app_valid), .app(app), .resp_valid(resp_valid),
    .resp_data(resp_data), .resp_ready(resp_ready));
  apm_term term (.clk(clk), .rstn(rstn), .slow(slow), .rx_valid(rx_valid), .rx(rx),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_ready(tx_ready));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic complete_run();
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard, well above the longest run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      complete_run();
    end
  end

  task automatic check(input string nm, input logic [39:0] exp, input logic [39:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // stalling consumer of command bytes
  always @(posedge clk) cmd_ready <= slow ? 1'($urandom_range(1, 0)) : 1'b1;

  // watcher: each output meets the oldest note; a surplus output never matches
  always @(posedge clk) begin
    if (rstn && tx_valid && tx_ready) begin
      if (txq.size() == 0) txq.push_back(~tx);
      check("tx", 40'(txq.pop_front()), 40'(tx));
    end
    if (rstn && cmd_valid && cmd_ready) begin
      if (cmdq.size() == 0) cmdq.push_back(~{cmd_end, cmd_byte});
      check("cmd", 40'(cmdq.pop_front()), 40'({cmd_end, cmd_byte}));
    end
    if (rstn && hdr_valid) begin
      if (hdrq.size() == 0) hdrq.push_back(~hdr);
      check("hdr", hdrq.pop_front(), hdr);
    end
  end

  // note one card byte; block marks only count in the block protocol
  task automatic ex(input logic [7:0] d);
    logic e;
    ecnt++;
    e = t1_mode && (ecnt % int'(apm_pkg::IFSD) == 0 || ecnt == etot);
    txq.push_back({d, e, e && ecnt != etot});
  endtask

  task automatic ex2(input logic [15:0] w);
    ex(w[15:8]);
    ex(w[7:0]);
  endtask

  function automatic logic [15:0] fix(input logic [15:0] s);
    return (s === apm_pkg::SW_OK) ? apm_pkg::SW_FALLBACK : s;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic lk(input logic [7:0] d, input logic be, input logic ch);
    term.q.push_back({d, be, ch});
  endtask

  task automatic send_hdr(input apm_pkg::apm_hdr_t h);
    hdrq.push_back(h);
    for (int i = 4; i >= 0; i--) lk(h[i*8 +: 8], 1'b0, 1'b0);
  endtask

  // one-cycle decision once the block waits; first edge skips a stale wait flag
  task automatic go(input apm_pkg::apm_case_t c, input logic ab, input logic [15:0] sw,
      input logic [8:0] av);
    int k;
    k = 0;
    tick(1);
    while (app_wait !== 1'b1 && k < 2000) begin
      tick(1);
      k++;
    end
    check("app_wait", 40'h1, 40'(app_wait));
    check("rx_ready", 40'h0, 40'(rx_ready));
    app_valid <= 1'b1;
    app <= '{c, ab, sw, av};
    tick(1);
    app_valid <= 1'b0;
  endtask

  // push response bytes, holding each until the buffer takes it
  task automatic rp(input int n);
    logic [7:0] d;
    int k;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      ex(d);
      resp_valid <= 1'b1;
      resp_data <= d;
      k = 0;
      do begin
        tick(1);
        refused += (resp_ready !== 1'b1);
        k++;
      end while (resp_ready !== 1'b1 && k < 2000);
    end
    resp_valid <= 1'b0;
  endtask

  task automatic drain();
    int k;
    k = 0;
    while ((txq.size() > 0 || cmdq.size() > 0) && k < 3000) begin
      tick(1);
      k++;
    end
    if (k == 3000) failures++;
    tick(2);
  endtask

  // case 2 outcome worked out from length asked and length available
  task automatic c2(input logic [7:0] ins, input logic [7:0] p3, input logic ab,
      input logic [15:0] sw, input logic [8:0] av);
    logic [8:0] le;
    le = (p3 == 8'h00) ? 9'h100 : {1'b0, p3};
    ecnt = 0;
    send_hdr('{8'h00, ins, 8'h00, 8'h00, p3});
    go(apm_pkg::CASE2, ab, sw, av);
    if (ab) begin
      ex2(fix(sw));
    end else if (le > av) begin
      ex2({apm_pkg::PB_RESEND, av[7:0]});
    end else if (le == av) begin
      ex(ins);
      rp(av);
      ex2(sw);
    end else begin
      ex(ins);
      rp(le);
      ex2({apm_pkg::PB_GET, 8'(av - le)});
    end
    drain();
  endtask

  // cases 3 and 4: data goes only after the procedure byte is back
  task automatic c34(input apm_pkg::apm_case_t c, input logic [7:0] p3, input logic ab,
      input logic [15:0] sw, input logic [8:0] av);
    logic [7:0] d;
    ecnt = 0;
    send_hdr('{8'h00, 8'hDA, 8'h00, 8'h00, p3});
    go(c, 1'b0, 16'h0000, 9'h000);
    ex(8'hDA);
    drain();
    for (int i = 0; i < p3; i++) begin
      d = 8'($urandom);
      cmdq.push_back({i == p3 - 1, d});
      lk(d, 1'b0, 1'b0);
    end
    go(c, ab, sw, av);
    if (c == apm_pkg::CASE3 && !ab) ex2(sw);
    else if (c == apm_pkg::CASE4 && !ab) ex2({apm_pkg::PB_GET, av[7:0]});
    else ex2(fix(sw));
    drain();
  endtask

  // block command of n bytes, first block of four chained to the rest
  task automatic t1cmd(input int n, input logic [15:0] sw, input logic [8:0] av);
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      cmdq.push_back({i == n - 1, d});
      lk(d, i == 3 || i == n - 1, i == 3);
    end
    ecnt = 0;
    go(apm_pkg::CASE4, 1'b0, sw, av);
    if ((sw[15:8] inside {8'h62, 8'h63} || sw[15:12] == 4'h9) && av > 0) begin
      etot = av + 2;
      rp(av);
    end else begin
      etot = 2;
    end
    ex2(sw);
    drain();
  endtask

  task automatic do_reset(input logic m);
    rstn <= 1'b0;
    t1_mode <= m;
    tick(4);
    term.q.delete();
    rstn <= 1'b1;
    tick(2);
  endtask

  initial begin
    rstn = 1'b0;
    t1_mode = 1'b0;
    slow = 1'b0;
    app_valid = 1'b0;
    app = '0;
    resp_valid = 1'b0;
    resp_data = 8'h00;
    void'($urandom(33));
    do_reset(1'b0);
    send_hdr('{8'h00, 8'hA4, 8'h00, 8'h00, 8'h00});
    go(apm_pkg::CASE1, 1'b0, apm_pkg::SW_OK, 9'h000);
    ex2(apm_pkg::SW_OK);
    drain();
    c2(8'hB0, 8'h04, 1'b0, apm_pkg::SW_OK, 9'h004);
    c2(8'hB0, 8'h0A, 1'b0, apm_pkg::SW_OK, 9'h005);
    c2(8'hB0, 8'h05, 1'b0, apm_pkg::SW_OK, 9'h005);
    c2(8'hB0, 8'h00, 1'b0, apm_pkg::SW_OK, 9'h014);
    c2(8'hB0, 8'h03, 1'b0, apm_pkg::SW_OK, 9'h014);
    c2(8'hB0, 8'h02, 1'b1, apm_pkg::SW_OK, 9'h014);
    c2(8'hB0, 8'h02, 1'b1, 16'h6A82, 9'h014);
    slow <= 1'b1;
    refused = 0;
    c2(8'hB0, 8'h00, 1'b0, 16'h6281, 9'h100);
    check("fifo_full", 40'h1, 40'(refused > 0));
    c34(apm_pkg::CASE3, 8'hFF, 1'b0, apm_pkg::SW_OK, 9'h000);
    c34(apm_pkg::CASE3, 8'h01, 1'b1, 16'h6A82, 9'h000);
    c34(apm_pkg::CASE4, 8'h02, 1'b0, apm_pkg::SW_OK, 9'h030);
    c2(8'hC0, 8'h30, 1'b0, apm_pkg::SW_OK, 9'h030);
    c34(apm_pkg::CASE4, 8'h02, 1'b1, 16'h6283, 9'h000);
    c2(8'hC0, 8'h00, 1'b0, 16'h6283, 9'h003);
    c34(apm_pkg::CASE4, 8'h02, 1'b1, apm_pkg::SW_OK, 9'h000);
    c34(apm_pkg::CASE4, 8'h02, 1'b1, 16'h6A82, 9'h000);
    do_reset(1'b1);
    t1cmd(9, apm_pkg::SW_OK, 9'h028);
    t1cmd(9, 16'h6A82, 9'h005);
    t1cmd(6, 16'h6310, 9'h003);
    complete_run();
  end
endmodule
